// [test_thermal_status_flags.sv]
// Purpose: reads both status registers while a modelled engine feeds readings
// Assumes: default address variant; engine answers each start one cycle later
// Notes: limits sit at the boundary so equal readings must leave flags clear
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module test_thermal_status_flags;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic host_low;
  logic sda;
  logic data_oe;
  logic conv_start;
  logic conv_done = 1'b0;
  logic [2:0] conv_ch;
  logic ot_oe;
  logic ot_out;
  logic sda_out;
  logic standby = 1'b0;
  tsf_pkg::tsf_res_t conv_res = '0;
  tsf_pkg::tsf_limits_t ot_limit = {8'hfb, 8'h46, 8'h3c, 8'h32};
  logic signed [7:0] temps [7];
  logic [6:0] faults = 7'h00;
  int starts [7];
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic pend = 1'b0;
  logic [2:0] pch;
  logic [7:0] rd;
  logic ok;
  int chs [4] = '{1, 4, 5, 6};
  int bts [4] = '{0, 3, 4, 5};
  localparam logic [6:0] ADDR = 7'h1a;
  assign sda = !(host_low || data_oe);
  always #12.5 clk = ~clk;
  tsf_host_model host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(host_low));
  tsf_top DUT (.clk(clk), .rst_n(rst_n), .smb_clk_in(scl), .smb_data_in(sda), .smb_data_out(sda_out),
    .smb_data_oe(data_oe), .standby_input(standby), .conv_start(conv_start), .conv_ch(conv_ch),
    .conv_done(conv_done), .conv_res(conv_res), .ot_limit(ot_limit), .overtemp_output_out(ot_out),
    .overtemp_output_oe(ot_oe));
  // engine stand-in: one result per start, taken from the temps and faults tables
  always @(negedge clk) begin
    conv_done = 1'b0;
    // a reset drops the conversion in flight, so no stale result follows release
    if (!rst_n) begin
      pend = 1'b0;
    end else if (conv_start) begin
      pend = 1'b1;
      pch = conv_ch;
      starts[conv_ch]++;
    end else if (pend) begin
      pend = 1'b0;
      conv_done = 1'b1;
      conv_res = '{pch, temps[pch], faults[pch]};
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    host.read_reg(ADDR, cmd, rd, ok);
    `CHK(ok, 1'b1)
    `CHK(rd, exp)
  endtask
  // readings exactly at each limit: strictly-greater compare keeps flags clear
  task automatic at_limit();
    temps[1] = ot_limit[0];
    temps[4] = ot_limit[1];
    temps[5] = ot_limit[2];
    temps[6] = ot_limit[3];
  endtask
  task automatic wc(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    temps = '{8'h19, 8'h00, 8'h7f, 8'h7f, 8'h00, 8'h00, 8'h00};
    at_limit();
    wc(3);
    rst_n = 1'b1;
    wc(100);
    rd_chk(tsf_pkg::CMD_OVERTEMP_STATUS, 8'h00);
    rd_chk(tsf_pkg::CMD_FAULT_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      at_limit();
      temps[chs[i]] = temps[chs[i]] + 8'sh01;
      wc(100);
      rd_chk(tsf_pkg::CMD_OVERTEMP_STATUS, 8'h01 << bts[i]);
      `CHK(ot_oe, 1'b1)
      `CHK(ot_out, 1'b0)
    end
    for (int i = 0; i < 4; i++) begin
      temps[chs[i]] = temps[chs[i]] + 8'sh01;
    end
    wc(100);
    rd_chk(tsf_pkg::CMD_OVERTEMP_STATUS, 8'h39);
    at_limit();
    wc(100);
    rd_chk(tsf_pkg::CMD_OVERTEMP_STATUS, 8'h00);
    `CHK(ot_oe, 1'b0)
    // unused mapping command reads as zero
    rd_chk(8'h00, 8'h00);
    faults = 7'h24;
    temps[5] = temps[5] + 8'sh01;
    wc(100);
    rd_chk(tsf_pkg::CMD_FAULT_STATUS, 8'h24);
    rd_chk(tsf_pkg::CMD_OVERTEMP_STATUS, 8'h00);
    starts = '{0, 0, 0, 0, 0, 0, 0};
    wc(200);
    `CHK(starts[2], 0)
    `CHK(starts[5], 0)
    `CHK(starts[0] > 0, 1'b1)
    // standby lets the conversion in flight finish, then no new start
    standby = 1'b1;
    wc(10);
    starts = '{0, 0, 0, 0, 0, 0, 0};
    wc(100);
    `CHK(starts.sum(), 0)
    standby = 1'b0;
    wc(100);
    `CHK(starts[0] > 0, 1'b1)
    faults = 7'h00;
    wc(100);
    rd_chk(tsf_pkg::CMD_FAULT_STATUS, 8'h24);
    // the other variant addresses and a neighbour must not be acknowledged
    foreach (chs[i]) begin
      host.read_reg(i == 0 ? 7'h1c : i == 1 ? 7'h4d : i == 2 ? 7'h4f : 7'h1b,
        tsf_pkg::CMD_FAULT_STATUS, rd, ok);
      `CHK(ok, 1'b0)
    end
    `CHK(sda_out, 1'b0)
    rd_chk(tsf_pkg::CMD_FAULT_STATUS, 8'h24);
    rst_n = 1'b0;
    wc(3);
    rst_n = 1'b1;
    wc(100);
    rd_chk(tsf_pkg::CMD_FAULT_STATUS, 8'h00);
    conclude();
  end
endmodule

// [tsf_host_model.sv]
// Purpose: smbus host controller that reads one status byte per transaction
// Assumes: sda_in is the resolved wire with its pull-up; scl is never stretched
// Notes: all pin changes land on falling clk edges; 80 clk per bit
`timescale 1ns/10ps
module tsf_host_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  localparam int HALF = 40;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // data changes mid-low, well after the slave's hold window has closed
  task automatic bit_io(input logic b, output logic r);
    wt(HALF / 2);
    sda_low = !b;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF / 2);
    r = sda_in;
    wt(HALF / 2);
    scl = 1'b0;
  endtask
  // ninth bit is always released: ack phase on writes, nack on reads
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic nine;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, nine);
    ack = !nine;
  endtask
  task automatic start_cond();
    wt(HALF / 2);
    sda_low = 1'b0;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    wt(HALF / 2);
    sda_low = 1'b1;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd, output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic a1;
    logic a2;
    logic a3;
    logic a4;
    start_cond();
    xfer({addr, 1'b0}, rx, a1);
    xfer(cmd, rx, a2);
    start_cond();
    xfer({addr, 1'b1}, rx, a3);
    xfer(8'hff, data, a4);
    stop_cond();
    ok = a1 & a2 & a3;
  endtask
endmodule

// [tsf_pkg.sv]
// Purpose: shared constants and types for the thermal status flag block
// Assumes: 40 MHz system clock, SMBus slave without clock stretching
// Notes: command codes select which status register a read returns
package tsf_pkg;
  localparam int CLK_NS = 25;
  localparam int T_HOLD_NS = 300;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] HOLD_LOAD = 5'(HOLD_CYC);
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [7:0] CMD_OVERTEMP_STATUS = 8'h43;
  localparam logic [7:0] CMD_FAULT_STATUS = 8'h44;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [3:0][6:0] SLAVE_ADDRS = {7'h4f, 7'h4d, 7'h1c, 7'h1a};
  localparam int N_OT = 4;
  localparam logic [3:0][2:0] OT_CH = {3'h6, 3'h5, 3'h4, 3'h1};
  localparam logic [3:0][2:0] OT_BIT = {3'h5, 3'h4, 3'h3, 3'h0};
  localparam int FIRST_REMOTE = 1;
  localparam int LAST_REMOTE = 6;
  localparam logic [2:0] LOCAL_CH = 3'h0;
  localparam logic [2:0] LAST_CH = 3'h6;
  localparam int N_CH = 7;

  typedef struct packed {
    logic [2:0] ch;
    logic signed [7:0] temp;
    logic fault;
  } tsf_res_t;

  typedef logic [3:0][7:0] tsf_limits_t;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ADDR_ACK  = 10'h004,
    ST_CMD       = 10'h008,
    ST_CMD_ACK   = 10'h010,
    ST_WDATA     = 10'h020,
    ST_WDATA_ACK = 10'h040,
    ST_RDATA     = 10'h080,
    ST_RACK      = 10'h100,
    ST_IGNORE    = 10'h200
  } tsf_smb_state_t;

  typedef enum logic [1:0] {
    SEQ_START = 2'h1,
    SEQ_WAIT  = 2'h2
  } tsf_seq_state_t;
endpackage

// [tsf_seq.sv]
// Purpose: steps the conversion engine through local and remote channels
// Assumes: engine answers every start with exactly one conv_done
// Notes: the local channel is never masked, so the search always ends
`timescale 1ns/10ps
module tsf_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standby,
  input wire logic [6:0] fault_mask,
  input wire logic conv_done,
  output logic conv_start,
  output logic [2:0] conv_ch
);
  tsf_pkg::tsf_seq_state_t state_r;
  logic start_r;
  logic [2:0] ch_r;

  function automatic logic [2:0] next_ch(input logic [2:0] cur, input logic [6:0] mask);
    logic [2:0] n;
    logic found;
    n = cur;
    found = 1'b0;
    for (int k = 0; k < tsf_pkg::N_CH; k++) begin
      if (!found) begin
        n = (n == tsf_pkg::LAST_CH) ? tsf_pkg::LOCAL_CH : 3'(n + 3'h1);
        found = !mask[n];
      end
    end
    return n;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= tsf_pkg::SEQ_START;
      start_r <= 1'b0;
      ch_r <= tsf_pkg::LOCAL_CH;
    end else begin
      case (state_r)
        tsf_pkg::SEQ_START: begin
          // standby holds off new conversions, the one in flight still completes
          if (!standby) begin
            start_r <= 1'b1;
            state_r <= tsf_pkg::SEQ_WAIT;
          end
        end
        tsf_pkg::SEQ_WAIT: begin
          start_r <= 1'b0;
          if (conv_done) begin
            ch_r <= next_ch(ch_r, fault_mask);
            state_r <= tsf_pkg::SEQ_START;
          end
        end
        default: state_r <= tsf_pkg::SEQ_START;
      endcase
    end
  end

  assign conv_start = start_r;
  assign conv_ch = ch_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_skip_faulted: assert property (start_r |-> !fault_mask[ch_r])
    else $error("conversion started on a faulted channel");
endmodule

// [tsf_top.sv]
// Purpose: status flags of a remote-diode monitor, read over an SMBus slave
// Assumes: conversion results arrive on clk; SMBus pins are asynchronous
// Notes: status registers are read only; written data bytes are acked and dropped
//
// Summary of operation
// - Bit 0 of the overtemperature status is 1 while the last channel 1 reading is above its limit.
// - Bit 3 of the overtemperature status is 1 while the last channel 4 reading is above its limit.
// - Bit 4 of the overtemperature status is 1 while the last channel 5 reading is above its limit.
// - Bit 5 of the overtemperature status is 1 while the last channel 6 reading is above its limit.
// - A shorted or open diode on remote channel N sets bit N of the fault status, for N from 1 to 6.
// - The slave answers only its fixed 7-bit address, one of four variants, and the host uses it.
// - Channels marked faulted are skipped by the measurement sequence.
`timescale 1ns/10ps
module tsf_top #(
  parameter logic [1:0] ADDR_SEL = 2'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe,
  input wire logic standby_input,
  output logic conv_start,
  output logic [2:0] conv_ch,
  input wire logic conv_done,
  input wire tsf_pkg::tsf_res_t conv_res,
  input wire tsf_pkg::tsf_limits_t ot_limit,
  output logic overtemp_output_out,
  output logic overtemp_output_oe
);
  localparam logic [6:0] SLAVE_ADDR = tsf_pkg::SLAVE_ADDRS[ADDR_SEL];

  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, standby_input_m, standby_input_s;
  logic scl_rise, scl_fall, bus_start, bus_stop, drv_evt;
  logic [4:0] hold_r;
  logic [3:0] ot_flag_r;
  logic [3:0] ot_hit;
  logic [6:1] fault_r;
  logic [7:0] ot_status, fault_status, rd_val;
  logic [7:0] sr_r, tx_r, ptr_r;
  logic [3:0] bitcnt_r;
  logic rw_r, mack_r, sda_oe_r, overtemp_output_oe_r;
  tsf_pkg::tsf_smb_state_t state_r;

  // pins are asynchronous to clk; only the second and third stages are ever read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      standby_input_m <= 1'b0;
      standby_input_s <= 1'b0;
    end else begin
      scl_m <= smb_clk_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= smb_data_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      standby_input_m <= standby_input;
      standby_input_s <= standby_input_m;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // data changes wait out the hold time after the clock falls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 5'h00;
    end else if (scl_fall) begin
      hold_r <= tsf_pkg::HOLD_LOAD;
    end else if (hold_r != 5'h00) begin
      hold_r <= 5'(hold_r - 5'h01);
    end
  end
  assign drv_evt = (hold_r == 5'h01);

  // overtemperature flags follow the latest conversion of their channel
  for (genvar i = 0; i < tsf_pkg::N_OT; i++) begin : g_ot
    assign ot_hit[i] = !conv_res.fault && (conv_res.temp > $signed(ot_limit[i]));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ot_flag_r[i] <= 1'b0;
      end else if (conv_done && conv_res.ch == tsf_pkg::OT_CH[i]) begin
        ot_flag_r[i] <= ot_hit[i];
      end
    end
  end

  // fault bits are sticky: a faulted channel is never converted again to clear it
  for (genvar c = tsf_pkg::FIRST_REMOTE; c <= tsf_pkg::LAST_REMOTE; c++) begin : g_fault
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        fault_r[c] <= 1'b0;
      end else if (conv_done && conv_res.fault && conv_res.ch == 3'(c)) begin
        fault_r[c] <= 1'b1;
      end
    end
  end

  always_comb begin
    ot_status = 8'h00;
    for (int i = 0; i < tsf_pkg::N_OT; i++) begin
      ot_status[tsf_pkg::OT_BIT[i]] = ot_flag_r[i];
    end
  end
  assign fault_status = {1'b0, fault_r, 1'b0};

  always_comb begin
    if (ptr_r == tsf_pkg::CMD_OVERTEMP_STATUS) begin
      rd_val = ot_status;
    end else if (ptr_r == tsf_pkg::CMD_FAULT_STATUS) begin
      rd_val = fault_status;
    end else begin
      rd_val = tsf_pkg::UNMAPPED_VALUE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= 8'h00;
    end else if (scl_rise && (state_r == tsf_pkg::ST_ADDR || state_r == tsf_pkg::ST_CMD ||
                              state_r == tsf_pkg::ST_WDATA)) begin
      sr_r <= {sr_r[6:0], sda_s};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= tsf_pkg::ST_IDLE;
      bitcnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      tx_r <= 8'h00;
      ptr_r <= tsf_pkg::CMD_RESET;
    end else if (bus_start) begin
      state_r <= tsf_pkg::ST_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      state_r <= tsf_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        tsf_pkg::ST_ADDR, tsf_pkg::ST_CMD, tsf_pkg::ST_WDATA: begin
          if (scl_rise) begin
            bitcnt_r <= 4'(bitcnt_r + 4'h1);
          end else if (drv_evt && bitcnt_r == tsf_pkg::BYTE_BITS) begin
            if (state_r == tsf_pkg::ST_ADDR) begin
              if (sr_r[7:1] == SLAVE_ADDR) begin
                sda_oe_r <= 1'b1;
                rw_r <= sr_r[0];
                state_r <= tsf_pkg::ST_ADDR_ACK;
              end else begin
                state_r <= tsf_pkg::ST_IGNORE;
              end
            end else if (state_r == tsf_pkg::ST_CMD) begin
              ptr_r <= sr_r;
              sda_oe_r <= 1'b1;
              state_r <= tsf_pkg::ST_CMD_ACK;
            end else begin
              sda_oe_r <= 1'b1;
              state_r <= tsf_pkg::ST_WDATA_ACK;
            end
          end
        end
        tsf_pkg::ST_ADDR_ACK: begin
          if (drv_evt) begin
            bitcnt_r <= 4'h0;
            if (rw_r) begin
              tx_r <= rd_val;
              sda_oe_r <= !rd_val[7];
              state_r <= tsf_pkg::ST_RDATA;
            end else begin
              sda_oe_r <= 1'b0;
              state_r <= tsf_pkg::ST_CMD;
            end
          end
        end
        tsf_pkg::ST_CMD_ACK, tsf_pkg::ST_WDATA_ACK: begin
          if (drv_evt) begin
            bitcnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            state_r <= tsf_pkg::ST_WDATA;
          end
        end
        tsf_pkg::ST_RDATA: begin
          if (drv_evt) begin
            if (bitcnt_r == tsf_pkg::LAST_TX_BIT) begin
              sda_oe_r <= 1'b0;
              mack_r <= 1'b0;
              state_r <= tsf_pkg::ST_RACK;
            end else begin
              sda_oe_r <= !tx_r[6];
              tx_r <= {tx_r[6:0], 1'b0};
              bitcnt_r <= 4'(bitcnt_r + 4'h1);
            end
          end
        end
        tsf_pkg::ST_RACK: begin
          if (scl_rise) begin
            mack_r <= !sda_s;
          end else if (drv_evt) begin
            bitcnt_r <= 4'h0;
            if (mack_r) begin
              tx_r <= rd_val;
              sda_oe_r <= !rd_val[7];
              state_r <= tsf_pkg::ST_RDATA;
            end else begin
              state_r <= tsf_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // open-drain alarm pin pulls low while any overtemperature flag stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_output_oe_r <= 1'b0;
    end else begin
      overtemp_output_oe_r <= |ot_flag_r;
    end
  end

  tsf_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .standby(standby_input_s),
    .fault_mask({fault_r, 1'b0}),
    .conv_done(conv_done),
    .conv_start(conv_start),
    .conv_ch(conv_ch)
  );

  assign smb_data_out = 1'b0;
  assign smb_data_oe = sda_oe_r;
  assign overtemp_output_out = 1'b0;
  assign overtemp_output_oe = overtemp_output_oe_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence addr_byte_done;
    drv_evt && state_r == tsf_pkg::ST_ADDR && bitcnt_r == tsf_pkg::BYTE_BITS && !bus_start && !bus_stop;
  endsequence

  chk_ch1_overtemp: assert property (conv_done && conv_res.ch == 3'h1 |=> ot_status[0] == $past(ot_hit[0]))
    else $error("channel 1 overtemperature bit wrong");
  chk_ch4_overtemp: assert property (conv_done && conv_res.ch == 3'h4 |=> ot_status[3] == $past(ot_hit[1]))
    else $error("channel 4 overtemperature bit wrong");
  chk_ch5_overtemp: assert property (conv_done && conv_res.ch == 3'h5 |=> ot_status[4] == $past(ot_hit[2]))
    else $error("channel 5 overtemperature bit wrong");
  chk_ch6_overtemp: assert property (conv_done && conv_res.ch == 3'h6 |=> ot_status[5] == $past(ot_hit[3]))
    else $error("channel 6 overtemperature bit wrong");
  chk_fault_set: assert property (conv_done && conv_res.fault && conv_res.ch != 3'h0 && conv_res.ch != 3'h7
                                  |=> fault_status[$past(conv_res.ch)])
    else $error("diode fault bit not set");
  chk_addr_match: assert property (addr_byte_done ##0 (sr_r[7:1] == SLAVE_ADDR) |=> sda_oe_r throughout
                                   (state_r == tsf_pkg::ST_ADDR_ACK)[*1])
    else $error("own address not acknowledged");
  chk_foreign_quiet: assert property (addr_byte_done ##0 (sr_r[7:1] != SLAVE_ADDR) |=>
                                      (!sda_oe_r && state_r == tsf_pkg::ST_IGNORE)[*2])
    else $error("foreign address drove the data line");
  chk_reserved_zero: assert property (ot_status[7:6] == 2'h0 && ot_status[2:1] == 2'h0 &&
                                      fault_status[7] == 1'b0 && fault_status[0] == 1'b0)
    else $error("reserved status bit set");
  chk_overtemp_output_pin: assert property ($rose(|ot_flag_r) |=> overtemp_output_oe_r)
    else $error("alarm pin did not follow flags");
endmodule
